// ===== hw/rtcpi_pkg.sv
// rtcpi_pkg: constants, register map and state types shared by the
// device end, the host end and the testbench.
// assumes a 20 MHz aclk on both ends.
package rtcpi_pkg;
	// clock and time base
	localparam int CLK_HZ        = 20_000_000;
	localparam int QUARTER_MS    = 250;
	localparam int QUARTER_CYC   = CLK_HZ / 1000 * QUARTER_MS;
	localparam int INC_DELAY_US  = 92;
	localparam int INC_DELAY_CYC = CLK_HZ / 1_000_000 * INC_DELAY_US;
	localparam int INIT_MS       = 1000;
	localparam int INIT_CYC      = CLK_HZ / 1000 * INIT_MS;
	localparam int ADJ_MAX_US    = 3784;
	localparam int ADJ_STEPS     = 63;
	localparam int ADJ_STEP_CYC  = CLK_HZ / 1_000_000 * ADJ_MAX_US / ADJ_STEPS;
	localparam int ADJ_PERIOD_S  = 20;
	localparam int SCL_HZ        = 400_000;
	localparam int SCL_QCYC      = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
	localparam int PON_CAP_CYC   = 3;
	// two-wire slave address of the device
	localparam logic [6:0] DEV_ADDR = 7'h32;
	// device register indices
	localparam logic [3:0] REG_SEC     = 4'h0;
	localparam logic [3:0] REG_MIN     = 4'h1;
	localparam logic [3:0] REG_HOUR    = 4'h2;
	localparam logic [3:0] REG_WDAY    = 4'h3;
	localparam logic [3:0] REG_DAY     = 4'h4;
	localparam logic [3:0] REG_MON     = 4'h5;
	localparam logic [3:0] REG_YEAR    = 4'h6;
	localparam logic [3:0] REG_ADJ     = 4'h7;
	localparam logic [3:0] REG_AW_MIN  = 4'h8;
	localparam logic [3:0] REG_AW_HOUR = 4'h9;
	localparam logic [3:0] REG_AW_WDAY = 4'hA;
	localparam logic [3:0] REG_AD_MIN  = 4'hB;
	localparam logic [3:0] REG_AD_HOUR = 4'hC;
	localparam logic [3:0] REG_CTRL1   = 4'hE;
	localparam logic [3:0] REG_CTRL2   = 4'hF;
	// field positions
	localparam int C1_WEEK_ALARM_ENABLE = 7;
	localparam int C1_DAY_ALARM_ENABLE = 6;
	localparam int C1_PON  = 4;
	localparam int C2_PERIODIC_FLAG = 2;
	localparam int C2_WAFG = 1;
	localparam int C2_DAFG = 0;
	localparam int ADJ_SIGN = 6;
	localparam logic [7:0] DAY_RESET = 8'h01;
	// periodic_select codes
	localparam logic [2:0] SEL_OFF   = 3'h0;
	localparam logic [2:0] SEL_LOW   = 3'h1;
	localparam logic [2:0] SEL_2HZ   = 3'h2;
	localparam logic [2:0] SEL_1HZ   = 3'h3;
	localparam logic [2:0] SEL_SEC   = 3'h4;
	localparam logic [2:0] SEL_MIN   = 3'h5;
	localparam logic [2:0] SEL_HOUR  = 3'h6;
	localparam logic [2:0] SEL_MONTH = 3'h7;
	// alarm values that never match a valid time
	localparam logic [7:0] ALARM_CANCEL_W = 8'h55;
	localparam logic [7:0] ALARM_CANCEL_D = 8'h56;
	// host register byte offsets and fields
	localparam logic [7:0] H_CTRL     = 8'h00;
	localparam logic [7:0] H_STATUS   = 8'h04;
	localparam logic [1:0] H_DATA_SEL = 2'h1;
	localparam int HC_GO   = 0;
	localparam int HC_RD   = 1;
	localparam int HC_PTR  = 8;
	localparam int HC_LEN  = 16;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_ADDR  = 5'b00010,
		S_PTR   = 5'b00100,
		S_WDATA = 5'b01000,
		S_RDATA = 5'b10000
	} rtcpi_slv_t;
	typedef enum logic [3:0] {
		M_IDLE  = 4'b0001,
		M_START = 4'b0010,
		M_BIT   = 4'b0100,
		M_STOP  = 4'b1000
	} rtcpi_mst_t;
endpackage

// ===== hw/rtcpi_link_if.sv
// rtcpi_link_if: the two-wire link, interrupt and supply-detect lines.
// assumes pull-ups on every line: a line is low while any end pulls it.
`timescale 1ns/10ps
interface rtcpi_link_if;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic int_o;
	logic int_oe;
	logic sdet_o;
	logic sdet_oe;
	logic scl;
	logic sda;
	logic interrupt_out_n;
	logic supply_detect_out_n;
	// wired resolution of the open-drain lines
	assign scl = !(scl_h_oe && !scl_h_o);
	assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
	assign interrupt_out_n = !(int_oe && !int_o);
	assign supply_detect_out_n = !(sdet_oe && !sdet_o);
	modport host (output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe,
		input scl, sda, interrupt_out_n, supply_detect_out_n);
	modport dev (output sda_d_o, sda_d_oe, int_o, int_oe, sdet_o, sdet_oe,
		input scl, sda);
endinterface

// ===== hw/rtcpi_device.sv
// rtcpi_device: clock counters, periodic and alarm interrupt, two-wire
// register slave of the real-time clock.
// assumes the link lines come from another clock domain; the quarter
// second time base is counted from aclk.
// Behaviour
// - code 000 releases pin, 001 holds low
// - codes 010/011 give 2 Hz/1 Hz square wave
// - seconds increment 92 us after pulse fall
// - seconds write clears divider, pin goes low
// - level mode holds low until flag cleared
// - code 100 interrupts every second increment
// - code 101 interrupts at seconds 00
// - code 110 interrupts at minute, second 00
// - code 111 interrupts at month start
// - adjustment alters first quarter every 20 s
// - host waits for supply detect high
// - power_on_flag zero after backup power-up
// - host writes all counters in one transaction
// - host finishes counter access within 0.5 s
// - host reads all counters in one transaction
// - host uses level mode, then clears flag
// - host reads all counters first after write
// - host disables alarm while changing it
// - host cancels alarms with unmatched patterns
// - interrupt sources combine as wired OR
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module rtcpi_device #(
	parameter int QUARTER  = rtcpi_pkg::QUARTER_CYC,
	parameter int INIT     = rtcpi_pkg::INIT_CYC,
	parameter int ADJ_STEP = rtcpi_pkg::ADJ_STEP_CYC
) (
	input  wire logic   aclk,
	input  wire logic   aresetn,
	input  wire logic   ce,
	input  wire logic   power_from_backup,
	rtcpi_link_if.dev   link
);
	import rtcpi_pkg::*;

	logic [7:0]  regs [16];
	logic [2:0]  sy1;
	logic [2:0]  sy2;
	logic        scl_q;
	logic        sda_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	rtcpi_slv_t  st;
	logic [3:0]  bc;
	logic [7:0]  sh;
	logic [7:0]  tx;
	logic [3:0]  ptr;
	logic        rw;
	logic        mack;
	logic        drv;
	logic        wr_en;
	logic [3:0]  wr_addr;
	logic [7:0]  wr_data;
	logic [31:0] qcnt;
	logic [31:0] qlen;
	logic [31:0] adj_cyc;
	logic [1:0]  q;
	logic [31:0] dcnt;
	logic [4:0]  adj_sec;
	logic        sec_tick;
	logic        tick_d;
	logic [31:0] icnt;
	logic        per_low;
	logic        ev;
	logic        aw_hit;
	logic        ad_hit;
	logic        int_q;
	logic [2:0]  sel;

	assign sel = regs[REG_CTRL1][2:0];

	// two-stage synchronisers for scl, sda and the backup strap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sy1 <= 3'h3;
			sy2 <= 3'h3;
		end else if (ce) begin
			sy1 <= {power_from_backup, link.sda, link.scl};
			sy2 <= sy1;
		end
	end

	// delayed copies for edge detection of the synchronised lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_q <= sy2[0];
			sda_q <= sy2[1];
		end
	end

	assign scl_rise = sy2[0] && !scl_q;
	assign scl_fall = !sy2[0] && scl_q;
	assign start_c  = scl_q && sy2[0] && sda_q && !sy2[1];
	assign stop_c   = scl_q && sy2[0] && !sda_q && sy2[1];

	// two-wire slave: address, pointer, then auto-incrementing data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st      <= S_IDLE;
			bc      <= 4'h0;
			sh      <= 8'h00;
			tx      <= 8'h00;
			ptr     <= 4'h0;
			rw      <= 1'b0;
			mack    <= 1'b0;
			drv     <= 1'b0;
			wr_en   <= 1'b0;
			wr_addr <= 4'h0;
			wr_data <= 8'h00;
		end else if (ce) begin
			wr_en <= 1'b0;
			if (start_c) begin
				st  <= S_ADDR;
				bc  <= 4'hF; // the clock fall ending a start is no bit
				drv <= 1'b0;
			end else if (stop_c) begin
				st  <= S_IDLE;
				drv <= 1'b0;
			end else if (scl_rise) begin
				if (bc != 4'h8)
					sh <= {sh[6:0], sy2[1]};
				else
					mack <= !sy2[1];
			end else if (scl_fall && st != S_IDLE) begin
				if (bc == 4'h7) begin
					bc <= 4'h8;
					case (st)
					S_ADDR: begin
						rw  <= sh[0];
						drv <= (sh[7:1] == DEV_ADDR);
						if (sh[7:1] != DEV_ADDR)
							st <= S_IDLE;
					end
					S_PTR: begin
						ptr <= sh[3:0];
						drv <= 1'b1;
					end
					S_WDATA: begin
						wr_en   <= 1'b1;
						wr_addr <= ptr;
						wr_data <= sh;
						ptr     <= ptr + 4'h1;
						drv     <= 1'b1;
					end
					default: drv <= 1'b0; // master acks a read byte
					endcase
				end else if (bc == 4'h8) begin
					bc  <= 4'h0;
					drv <= 1'b0;
					if ((st == S_ADDR && rw) || (st == S_RDATA && mack)) begin
						st  <= S_RDATA;
						tx  <= regs[ptr];
						drv <= !regs[ptr][7];
						ptr <= ptr + 4'h1;
					end else if (st == S_ADDR) begin
						st <= S_PTR;
					end else if (st == S_RDATA) begin
						st <= S_IDLE; // master ended the read
					end else begin
						st <= S_WDATA;
					end
				end else begin
					bc <= bc + 4'h1;
					if (st == S_RDATA) begin
						drv <= !tx[6];
						tx  <= {tx[6:0], 1'b0};
					end
				end
			end
		end
	end

	// quarter length, stretched or cut once per adjustment period
	assign adj_cyc = 32'(ADJ_STEP) * {26'h0, regs[REG_ADJ][5:0]};
	always_comb begin
		qlen = 32'(QUARTER);
		if (q == 2'h0 && adj_sec == 5'h0 && regs[REG_ADJ][5:0] != 6'h00) begin
			if (regs[REG_ADJ][ADJ_SIGN])
				qlen = 32'(QUARTER) - adj_cyc;
			else
				qlen = 32'(QUARTER) + adj_cyc;
		end
	end

	// divider below one second; the increment lags the second boundary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			qcnt     <= 32'h0;
			q        <= 2'h0;
			dcnt     <= 32'h0;
			adj_sec  <= 5'h0;
			sec_tick <= 1'b0;
			tick_d   <= 1'b0;
		end else if (ce) begin
			sec_tick <= 1'b0;
			tick_d   <= sec_tick;
			if (wr_en && wr_addr == REG_SEC) begin
				qcnt <= 32'h0;
				q    <= 2'h0;
				dcnt <= 32'h0;
			end else begin
				if (dcnt != 32'h0)
					dcnt <= dcnt - 32'h1;
				if (dcnt == 32'h1)
					sec_tick <= 1'b1;
				if (qcnt >= qlen - 32'h1) begin
					qcnt <= 32'h0;
					q    <= q + 2'h1;
					if (q == 2'h3)
						dcnt <= 32'(INC_DELAY_CYC);
				end else begin
					qcnt <= qcnt + 32'h1;
				end
				if (sec_tick)
					adj_sec <= (adj_sec == 5'(ADJ_PERIOD_S - 1)) ?
						5'h0 : adj_sec + 5'h1;
			end
		end
	end

	// power-up wait, supply detect release and strap capture point
	always_ff @(posedge aclk) begin
		if (!aresetn)
			icnt <= 32'h0;
		else if (ce && icnt < 32'(INIT))
			icnt <= icnt + 32'h1;
	end

	function automatic logic [7:0] days_in(input logic [7:0] mon,
		input logic [7:0] yr);
		case (mon)
		8'h02:   days_in = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
		8'h04, 8'h06, 8'h09, 8'h0B: days_in = 8'h1E;
		default: days_in = 8'h1F;
		endcase
	endfunction

	// event decode on the freshly incremented counters
	always_comb begin
		case (sel)
		SEL_2HZ, SEL_1HZ, SEL_SEC: ev = 1'b1;
		SEL_MIN:   ev = regs[REG_SEC] == 8'h00;
		SEL_HOUR:  ev = regs[REG_SEC] == 8'h00 &&
			regs[REG_MIN] == 8'h00;
		SEL_MONTH: ev = regs[REG_SEC] == 8'h00 &&
			regs[REG_MIN] == 8'h00 && regs[REG_HOUR] == 8'h00 &&
			regs[REG_DAY] == DAY_RESET;
		default:   ev = 1'b0;
		endcase
	end

	assign aw_hit = regs[REG_CTRL1][C1_WEEK_ALARM_ENABLE] && regs[REG_SEC] == 8'h00 &&
		regs[REG_MIN] == regs[REG_AW_MIN] &&
		regs[REG_HOUR] == regs[REG_AW_HOUR] &&
		regs[REG_AW_WDAY][regs[REG_WDAY][2:0]];
	assign ad_hit = regs[REG_CTRL1][C1_DAY_ALARM_ENABLE] && regs[REG_SEC] == 8'h00 &&
		regs[REG_MIN] == regs[REG_AD_MIN] &&
		regs[REG_HOUR] == regs[REG_AD_HOUR];

	// counters and flags; a hardware set wins over a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 16; i++)
				regs[i] <= 8'h00;
			regs[REG_DAY] <= DAY_RESET;
			regs[REG_MON] <= DAY_RESET;
		end else if (ce) begin
			if (sec_tick) begin
				if (regs[REG_SEC] >= 8'h3B) begin
					regs[REG_SEC] <= 8'h00;
					if (regs[REG_MIN] >= 8'h3B) begin
						regs[REG_MIN] <= 8'h00;
						if (regs[REG_HOUR] >= 8'h17) begin
							regs[REG_HOUR] <= 8'h00;
							regs[REG_WDAY] <= (regs[REG_WDAY] >= 8'h06) ?
								8'h00 : regs[REG_WDAY] + 8'h01;
							if (regs[REG_DAY] >= days_in(regs[REG_MON],
								regs[REG_YEAR])) begin
								regs[REG_DAY] <= DAY_RESET;
								if (regs[REG_MON] >= 8'h0C) begin
									regs[REG_MON]  <= DAY_RESET;
									regs[REG_YEAR] <= (regs[REG_YEAR] >= 8'h63) ?
										8'h00 : regs[REG_YEAR] + 8'h01;
								end else begin
									regs[REG_MON] <= regs[REG_MON] + 8'h01;
								end
							end else begin
								regs[REG_DAY] <= regs[REG_DAY] + 8'h01;
							end
						end else begin
							regs[REG_HOUR] <= regs[REG_HOUR] + 8'h01;
						end
					end else begin
						regs[REG_MIN] <= regs[REG_MIN] + 8'h01;
					end
				end else begin
					regs[REG_SEC] <= regs[REG_SEC] + 8'h01;
				end
			end
			if (wr_en) begin
				if (wr_addr == REG_CTRL2) // flags: 0 clears, 1 keeps
					regs[REG_CTRL2] <= {wr_data[7:3],
						regs[REG_CTRL2][2:0] & wr_data[2:0]};
				else
					regs[wr_addr] <= wr_data;
			end
			if (icnt == 32'(PON_CAP_CYC))
				regs[REG_CTRL1][C1_PON] <= !sy2[2];
			if (tick_d && ev)
				regs[REG_CTRL2][C2_PERIODIC_FLAG] <= 1'b1;
			if (tick_d && aw_hit)
				regs[REG_CTRL2][C2_WAFG] <= 1'b1;
			if (tick_d && ad_hit)
				regs[REG_CTRL2][C2_DAFG] <= 1'b1;
		end
	end

	// periodic pin level by select code
	always_comb begin
		case (sel)
		SEL_OFF: per_low = 1'b0;
		SEL_LOW: per_low = 1'b1;
		SEL_2HZ: per_low = !q[0];
		SEL_1HZ: per_low = !q[1];
		default: per_low = regs[REG_CTRL2][C2_PERIODIC_FLAG];
		endcase
	end

	// registered pin drive; sources merge as a wired OR of lows
	always_ff @(posedge aclk) begin
		if (!aresetn)
			int_q <= 1'b0;
		else if (ce)
			int_q <= per_low ||
				(regs[REG_CTRL2][C2_WAFG] && regs[REG_CTRL1][C1_WEEK_ALARM_ENABLE]) ||
				(regs[REG_CTRL2][C2_DAFG] &&
				regs[REG_CTRL1][C1_DAY_ALARM_ENABLE]);
	end

	assign link.sda_d_o  = 1'b0;
	assign link.sda_d_oe = drv;
	assign link.int_o    = 1'b0;
	assign link.int_oe   = int_q;
	assign link.sdet_o   = 1'b0;
	assign link.sdet_oe  = icnt < 32'(INIT);
endmodule

// ===== hw/rtcpi_host.sv
// rtcpi_host: AXI4-Lite commanded two-wire master for the clock device.
// assumes software builds the access sequences; one command per
// transaction, up to 16 data bytes.
`timescale 1ns/10ps
module rtcpi_host (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output wire logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output wire logic        wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output wire logic        arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	rtcpi_link_if.host       link
);
	import rtcpi_pkg::*;

	logic [7:0]  dbuf [16];
	logic [2:0]  sy1;
	logic [2:0]  sy2;
	logic        aw_got;
	logic        w_got;
	logic [7:0]  awa;
	logic [31:0] wd;
	logic [3:0]  ws;
	logic        do_wr;
	logic        go_req;
	logic        ctl_rd;
	logic [3:0]  ctl_ptr;
	logic [4:0]  ctl_len;
	rtcpi_mst_t  mst;
	logic [1:0]  ph;
	logic [7:0]  qc;
	logic        qt;
	logic [3:0]  bitn;
	logic [4:0]  bc;
	logic [7:0]  sh;
	logic [7:0]  rsh;
	logic        ack_s;
	logic        restarted;
	logic        nack;
	logic        scl_dn;
	logic        sda_dn;
	logic        busy;
	logic        rd_byte;

	// synchronisers for supply detect, interrupt and sda; supply detect
	// starts low so no command slips out before the real line is seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sy1 <= 3'h3;
			sy2 <= 3'h3;
		end else if (ce) begin
			sy1 <= {link.supply_detect_out_n, link.interrupt_out_n, link.sda};
			sy2 <= sy1;
		end
	end

	// write channels taken in either order, response after both
	assign awready = !aw_got && !bvalid;
	assign wready  = !w_got && !bvalid;
	assign do_wr   = aw_got && w_got;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got  <= 1'b0;
			awa    <= 8'h00;
			wd     <= 32'h0;
			ws     <= 4'h0;
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_got <= 1'b1;
				awa    <= awaddr;
			end
			if (wvalid && wready) begin
				w_got <= 1'b1;
				wd    <= wdata;
				ws    <= wstrb;
			end
			if (do_wr) begin
				aw_got <= 1'b0;
				w_got  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= (awa == H_CTRL || awa == H_STATUS ||
					awa[7:6] == H_DATA_SEL) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read channel answers one cycle after the address is taken
	assign arready = !rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp  <= RESP_OKAY;
				if (araddr == H_CTRL)
					rdata <= {11'h0, ctl_len, 4'h0, ctl_ptr, 6'h0, ctl_rd, 1'b0};
				else if (araddr == H_STATUS) // int level
					rdata <= {28'h0, sy2[2], !sy2[1], nack, busy};
				else if (araddr[7:6] == H_DATA_SEL)
					rdata <= {24'h0, dbuf[araddr[5:2]]};
				else begin
					rdata <= 32'h0;
					rresp <= RESP_SLVERR;
				end
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// a command is refused while busy or before supply detect releases
	assign busy   = mst != M_IDLE;
	assign go_req = do_wr && awa == H_CTRL && ws[0] && wd[HC_GO] &&
		!busy && sy2[2];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_rd  <= 1'b0;
			ctl_ptr <= 4'h0;
			ctl_len <= 5'h0;
		end else if (ce && go_req) begin
			ctl_rd  <= wd[HC_RD];
			ctl_ptr <= wd[HC_PTR +: 4];
			ctl_len <= (wd[HC_LEN +: 5] > 5'h10) ? 5'h10 : wd[HC_LEN +: 5];
		end
	end

	assign qt      = qc == 8'(SCL_QCYC - 1);
	assign rd_byte = restarted && bc != 5'h0;

	// bit engine: four quarter phases per bit, one action per phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mst       <= M_IDLE;
			ph        <= 2'h0;
			qc        <= 8'h00;
			bitn      <= 4'h0;
			bc        <= 5'h0;
			sh        <= 8'h00;
			rsh       <= 8'h00;
			ack_s     <= 1'b0;
			restarted <= 1'b0;
			nack      <= 1'b0;
			scl_dn    <= 1'b0;
			sda_dn    <= 1'b0;
			for (int i = 0; i < 16; i++)
				dbuf[i] <= 8'h00;
		end else if (ce) begin
			if (do_wr && awa[7:6] == H_DATA_SEL && ws[0])
				dbuf[awa[5:2]] <= wd[7:0];
			qc <= (qt || !busy) ? 8'h00 : qc + 8'h01;
			if (busy && qt)
				ph <= ph + 2'h1;
			case (mst)
			M_IDLE: begin
				ph <= 2'h0;
				if (go_req) begin
					mst       <= M_START;
					bc        <= 5'h0;
					restarted <= 1'b0;
					nack      <= 1'b0;
				end
			end
			M_START: if (qt) begin
				case (ph)
				2'h0: sda_dn <= 1'b0;
				2'h1: scl_dn <= 1'b0;
				2'h2: sda_dn <= 1'b1;
				default: begin
					scl_dn <= 1'b1;
					mst    <= M_BIT;
					bitn   <= 4'h0;
					sh     <= {DEV_ADDR, restarted};
				end
				endcase
			end
			M_BIT: if (qt) begin
				case (ph)
				2'h0: sda_dn <= (bitn == 4'h8) ?
					(rd_byte && bc != ctl_len) : (!rd_byte && !sh[7]);
				2'h1: scl_dn <= 1'b0;
				2'h2: begin
					if (bitn == 4'h8)
						ack_s <= sy2[0];
					else
						rsh <= {rsh[6:0], sy2[0]};
				end
				default: begin
					scl_dn <= 1'b1;
					sh     <= {sh[6:0], 1'b0};
					bitn   <= bitn + 4'h1;
					if (bitn == 4'h8) begin
						bitn <= 4'h0;
						if (!rd_byte && ack_s) begin
							nack <= 1'b1;
							mst  <= M_STOP;
						end else if (restarted) begin
							if (bc != 5'h0)
								dbuf[4'(bc - 5'h1)] <= rsh;
							if (bc == ctl_len)
								mst <= M_STOP;
							bc <= bc + 5'h1;
						end else if (bc == 5'h1 && ctl_rd) begin
							mst       <= M_START; // repeated start, no stop
							restarted <= 1'b1;
							bc        <= 5'h0;
						end else if (bc >= ctl_len + 5'h1) begin
							mst <= M_STOP;
						end else begin
							bc <= bc + 5'h1;
							// data byte n follows the address and the pointer
							sh <= (bc == 5'h0) ? {4'h0, ctl_ptr} :
								dbuf[4'(bc - 5'h1)];
						end
					end
				end
				endcase
			end
			M_STOP: if (qt) begin
				case (ph)
				2'h0: sda_dn <= 1'b1;
				2'h1: scl_dn <= 1'b0;
				2'h2: sda_dn <= 1'b0;
				default: mst <= M_IDLE; // well under 0.5 s
				endcase
			end
			default: mst <= M_IDLE;
			endcase
		end
	end

	assign link.scl_h_o  = 1'b0;
	assign link.scl_h_oe = scl_dn;
	assign link.sda_h_o  = 1'b0;
	assign link.sda_h_oe = sda_dn;
endmodule

// ===== tb/rtcpi_link_chk.sv
// rtcpi_link_chk: timing checks on the link between the two ends.
// assumes it sits beside the link interface, fed its lines by name.
`timescale 1ns/10ps
module rtcpi_link_chk #(
	parameter int INIT = 200
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl,
	input wire logic scl_h_oe,
	input wire logic sda_h_oe,
	input wire logic sda_d_oe,
	input wire logic int_oe,
	input wire logic sdet_oe,
	input wire logic supply_detect_out_n
);
	int unsigned since_rst;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles since reset release; saturates so it never wraps
	always_ff @(posedge aclk) begin
		if (!aresetn)
			since_rst <= 0;
		else if (since_rst < INIT + 8)
			since_rst <= since_rst + 1;
	end
	// start: clock stays high a while, then the master pulls it low
	sequence start_seq;
		scl [*8] ##[1:12] !scl;
	endsequence
	rst_idle_a: assert property (disable iff (1'b0)
		!aresetn |=> sdet_oe && !int_oe && !sda_d_oe && !scl_h_oe)
		else $error("lines not idle in reset");
	init_wait_a: assert property (
		!supply_detect_out_n |=> (scl && !sda_h_oe) [*2])
		else $error("link used before supply detect");
	init_time_a: assert property (
		$rose(supply_detect_out_n) |-> since_rst inside {[INIT-2:INIT+3]})
		else $error("supply detect delay wrong");
	start_form_a: assert property (
		$rose(sda_h_oe) && scl |=> start_seq)
		else $error("bad start condition");
	stop_form_a: assert property (
		$fell(sda_h_oe) && scl |=> scl [*8])
		else $error("bus not idle after stop");
	slave_sda_a: assert property (
		$changed(sda_d_oe) |-> !scl && !$past(scl))
		else $error("slave moved data while clock high");
	clk_low_a: assert property (
		$rose(scl_h_oe) |=> scl_h_oe [*8])
		else $error("clock low phase too short");
	clk_high_a: assert property (
		$fell(scl_h_oe) |=> !scl_h_oe [*8])
		else $error("clock high phase too short");
endmodule

// ===== tb/test_rtc_periodic_interrupt.sv
// test_rtc_periodic_interrupt: both ends joined, driven over AXI4-Lite.
// assumes shortened quarter and init counts set below.
`timescale 1ns/10ps
module test_rtc_periodic_interrupt;
	import rtcpi_pkg::*;
	localparam int Q = 3000;
	localparam int INIT = 200;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rs;
	logic [2:0]  sel [2] = '{SEL_2HZ, SEL_1HZ};
	int          failures, n_tests, n;
	time         t0;
	rtcpi_link_if rtcpi_link_if_i ();
	rtcpi_device #(.QUARTER(Q), .INIT(INIT), .ADJ_STEP(10)) rtcpi_device_i (
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.power_from_backup(1'b1), .link(rtcpi_link_if_i));
	rtcpi_host rtcpi_host_i (
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .link(rtcpi_link_if_i));
	rtcpi_link_chk #(.INIT(INIT)) rtcpi_link_chk_i (
		.aclk(aclk), .aresetn(aresetn), .scl(rtcpi_link_if_i.scl),
		.scl_h_oe(rtcpi_link_if_i.scl_h_oe),
		.sda_h_oe(rtcpi_link_if_i.sda_h_oe),
		.sda_d_oe(rtcpi_link_if_i.sda_d_oe),
		.int_oe(rtcpi_link_if_i.int_oe), .sdet_oe(rtcpi_link_if_i.sdet_oe),
		.supply_detect_out_n(rtcpi_link_if_i.supply_detect_out_n));
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// each channel is held until the rising edge that takes it
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// one-byte link command, then poll until the master is idle
	task automatic xfer(input logic rdn, input logic [3:0] p);
		axi_wr(H_CTRL, {11'h0, 5'h1, 4'h0, p, 6'h0, rdn, 1'b1}, rs);
		do
			axi_rd(H_STATUS, rd, rs);
		while (rd[0] === 1'b1);
	endtask
	task automatic wr1(input logic [3:0] p, input logic [7:0] v);
		axi_wr(8'h40, {24'h0, v}, rs);
		xfer(1'b0, p);
	endtask
	task automatic rd1(input logic [3:0] p);
		axi_wr(8'h40, 32'hAA, rs); // a stale byte must not pass as read data
		xfer(1'b1, p);
		axi_rd(8'h40, rd, rs);
	endtask
	// cycles the interrupt line stays at lvl, from a falling edge on
	task automatic span(input logic lvl, output int c);
		c = 0;
		while (rtcpi_link_if_i.interrupt_out_n === lvl) begin
			c++;
			@(negedge aclk);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// watchdog: the sequence needs roughly 89k cycles
	initial begin
		repeat (99000) @(posedge aclk);
		failures++;
		results();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// no link command until supply detect is seen high
		do
			axi_rd(H_STATUS, rd, rs);
		while (rd[3] !== 1'b1);
		chk("status", rd, 32'h8);
		axi_rd(8'h20, rd, rs);
		chk("unmapped rresp", rs, RESP_SLVERR);
		axi_wr(8'h20, 32'h0, rs);
		chk("unmapped bresp", rs, RESP_SLVERR);
		rd1(REG_CTRL1);
		chk("ctrl1", rd[7:0], 8'h00);
		wr1(REG_CTRL1, {5'h0, SEL_LOW});
		chk("fixed low", rtcpi_link_if_i.interrupt_out_n, 0);
		wr1(REG_CTRL1, {5'h0, SEL_OFF});
		chk("off", rtcpi_link_if_i.interrupt_out_n, 1);
		$display("test registers and static modes done");
		foreach (sel[i]) begin
			wr1(REG_CTRL1, {5'h0, sel[i]});
			wr1(REG_SEC, 8'h00);
			chk("sec write", rtcpi_link_if_i.interrupt_out_n, 0);
			@(negedge aclk);
			span(1'b0, n);
			span(1'b1, n);
			chk("high span", n, Q * (i + 1));
			span(1'b0, n);
			chk("low span", n, Q * (i + 1));
		end
		$display("test pulse modes done");
		t0 = $time;
		wr1(REG_CTRL1, {5'h0, SEL_SEC});
		wr1(REG_CTRL2, 8'h00);
		@(negedge aclk);
		span(1'b1, n);
		n = int'(($time - t0) / 50);
		chk("level fall", n inside {[2*Q+INC_DELAY_CYC:2*Q+INC_DELAY_CYC+5]},
			1);
		t0 = $time;
		// alarm cancel pattern written while the enables are still clear
		wr1(REG_AW_MIN, ALARM_CANCEL_W);
		chk("held low", rtcpi_link_if_i.interrupt_out_n, 0);
		rd1(REG_AW_MIN);
		chk("alarm cancel", rd[7:0], ALARM_CANCEL_W);
		rd1(REG_CTRL2);
		chk("flag", rd[C2_PERIODIC_FLAG], 1);
		wr1(REG_CTRL2, 8'h00);
		chk("released", rtcpi_link_if_i.interrupt_out_n, 1);
		@(negedge aclk);
		span(1'b1, n);
		chk("period", int'(($time - t0) / 50), 4 * Q);
		$display("test level second done");
		wr1(REG_CTRL1, {5'h0, SEL_MIN});
		wr1(REG_SEC, 8'd58);
		wr1(REG_CTRL2, 8'h00);
		@(negedge aclk);
		span(1'b1, n);
		chk("minute fall", n > 5 * Q && n < 8 * Q + 1900, 1);
		rd1(REG_SEC);
		chk("seconds", rd[7:0], 8'h00);
		$display("test level minute done");
		results();
	end
endmodule
